// ===== logic/see_slave.sv
// two-wire serial memory slave with self-timed program cycle
`timescale 1ns/1ps
`default_nettype none
module see_slave
	import see_pkg::*;
#(
	parameter int PROG_CYCLES = SEE_PROG_CYC
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_write_protect_input,
	output logic      o_sda,
	output logic      o_sda_oe_b,
	output logic      o_busy
);
	localparam int DEPTH = 1 << SEE_ADDR_W;

	logic                  scl_s;
	logic                  sda_s;
	logic                  wp_s;
	logic                  scl_d_r;
	logic                  sda_d_r;
	see_state_type         state_r;
	logic [3:0]            bit_r;
	logic [7:0]            shift_r;
	logic [SEE_ADDR_W-1:0] addr_r;
	logic                  wp_seen_r;
	logic                  ack_r;
	logic                  after_ack_r;
	logic                  pend_r;
	logic                  rd_ack_r;
	logic [22:0]           prog_cnt_r;
	// erased pattern until the first program cycle lands
	logic [7:0]            mem [DEPTH] = '{default: SEE_ERASED};
	logic [7:0]            pbuf [64];
	logic [63:0]           pvalid_r;
	logic [SEE_ADDR_W-1:0] row_r;
	logic                  drive_r;
	logic                  busy_r;

	see_sync u_scl (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_async(i_scl), .o_sync(scl_s));
	see_sync u_sda (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_async(i_sda), .o_sync(sda_s));
	see_sync u_wp  (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_async(i_write_protect_input), .o_sync(wp_s));

	wire scl_rise   = scl_s && !scl_d_r;
	wire scl_fall   = !scl_s && scl_d_r;
	wire start_cond = scl_s && scl_d_r && sda_d_r && !sda_s;
	wire stop_cond  = scl_s && scl_d_r && !sda_d_r && sda_s;
	wire [7:0] byte_in = {shift_r[6:0], sda_s};
	wire sel_match  = (byte_in[7:4] == SEE_TYPE_CODE) && (byte_in[3:1] == SEE_FIXED_BITS);
	wire byte_done  = scl_rise && (bit_r == SEE_LAST_BIT);
	wire in_ack     = (bit_r == SEE_ACK_SLOT);
	wire programming = (state_r == SEE_PROG);
	wire [7:0] rd_byte = mem[addr_r];
	wire [SEE_ADDR_W-1:0] page_next = {addr_r[SEE_ADDR_W-1:SEE_ROW_BITS],
		addr_r[SEE_ROW_BITS-1:0] + 6'h01};
	wire [SEE_ADDR_W-1:0] rd_next = addr_r + 15'h0001;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// latched row bytes are written into the array one byte per clock over the first 64 clocks of the program cycle
	always_ff @(posedge i_sys_clk) begin
		if (programming && prog_cnt_r < 23'h40 && pvalid_r[prog_cnt_r[5:0]]) begin
			mem[{row_r[SEE_ADDR_W-1:SEE_ROW_BITS], prog_cnt_r[5:0]}] <= pbuf[prog_cnt_r[5:0]];
		end
		if (state_r == SEE_WDATA && byte_done && !wp_seen_r) begin
			pbuf[addr_r[SEE_ROW_BITS-1:0]] <= byte_in;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state_r     <= SEE_IDLE;
			bit_r       <= 4'h0;
			shift_r     <= 8'h00;
			addr_r      <= '0;
			wp_seen_r   <= 1'b0;
			ack_r       <= 1'b0;
			after_ack_r <= 1'b0;
			pend_r      <= 1'b0;
			rd_ack_r    <= 1'b0;
			prog_cnt_r  <= 23'h0;
			pvalid_r    <= 64'h0;
			row_r       <= '0;
			drive_r     <= 1'b0;
			busy_r      <= 1'b0;
		end else if (programming) begin
			// bus is deaf here; polling select sees no ack
			drive_r <= 1'b0;
			if (prog_cnt_r == 23'(PROG_CYCLES - 1)) begin
				state_r  <= SEE_IDLE;
				busy_r   <= 1'b0;
				pvalid_r <= 64'h0;
			end else begin
				prog_cnt_r <= prog_cnt_r + 23'h1;
			end
		end else if (stop_cond) begin
			drive_r <= 1'b0;
			if (pend_r && after_ack_r) begin
				state_r    <= SEE_PROG;
				prog_cnt_r <= 23'h0;
				busy_r     <= 1'b1;
			end else begin
				state_r <= SEE_IDLE;
			end
			pend_r <= 1'b0;
		end else if (start_cond) begin
			state_r   <= SEE_SELECT;
			bit_r     <= 4'h0;
			drive_r   <= 1'b0;
			wp_seen_r <= wp_s;
		end else begin
			if (scl_rise) begin
				if ((state_r == SEE_SELECT || state_r == SEE_ADDR_HI || state_r == SEE_ADDR_LO)
					&& wp_s) begin
					wp_seen_r <= 1'b1;
				end
				if (in_ack) begin
					// ack slot closes the byte; the next rise is the stop slot
					bit_r       <= 4'h0;
					after_ack_r <= 1'b1;
					if (state_r == SEE_RDATA && !ack_r) begin
						rd_ack_r <= !sda_s;
						if (sda_s) begin
							state_r <= SEE_IDLE;
						end
					end
				end else if (state_r != SEE_IDLE) begin
					shift_r <= byte_in;
					bit_r   <= bit_r + 4'h1;
				end
			end
			if (byte_done) begin
				ack_r <= 1'b0;
				case (state_r)
				SEE_SELECT: begin
					if (!sel_match) begin
						state_r <= SEE_IDLE;
					end else begin
						ack_r    <= 1'b1;
						rd_ack_r <= 1'b1;
						state_r  <= byte_in[0] ? SEE_RDATA : SEE_ADDR_HI;
					end
				end
				SEE_ADDR_HI: begin
					ack_r  <= 1'b1;
					addr_r <= {byte_in[SEE_ADDR_W-9:0], addr_r[7:0]};
					state_r <= SEE_ADDR_LO;
				end
				SEE_ADDR_LO: begin
					ack_r   <= 1'b1;
					addr_r  <= {addr_r[SEE_ADDR_W-1:8], byte_in};
					row_r   <= {addr_r[SEE_ADDR_W-1:8], byte_in};
					state_r <= SEE_WDATA;
				end
				SEE_WDATA: begin
					ack_r <= !wp_seen_r;
					if (!wp_seen_r) begin
						pend_r <= 1'b1;
						pvalid_r[addr_r[SEE_ROW_BITS-1:0]] <= 1'b1;
						addr_r <= page_next;
					end
				end
				default: ;
				endcase
			end
			if (scl_fall) begin
				// stop slot is over once its clock falls
				if (bit_r != 4'h0) begin
					after_ack_r <= 1'b0;
				end
				if (in_ack) begin
					drive_r <= ack_r;
				end else if (state_r == SEE_RDATA && bit_r == 4'h0 && rd_ack_r) begin
					drive_r <= !rd_byte[7];
					shift_r <= rd_byte;
					addr_r  <= rd_next;
				end else if (state_r == SEE_RDATA && bit_r != 4'h0) begin
					drive_r <= !shift_r[7];
				end else begin
					drive_r <= 1'b0;
				end
			end
		end
	end

	sequence s_prog_trig;
		!programming && stop_cond && pend_r && after_ack_r;
	endsequence
	sequence s_good_sel;
		state_r == SEE_SELECT && byte_done && sel_match;
	endsequence
	sequence s_bad_sel;
		state_r == SEE_SELECT && byte_done && !sel_match;
	endsequence
	sequence s_wp_data;
		state_r == SEE_WDATA && byte_done && wp_seen_r;
	endsequence

	AST_PROG_START: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b) s_prog_trig |=> o_busy)
		else $error("program cycle missing after stop");
	AST_PROG_ONLY: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(o_busy) |-> $past(stop_cond && after_ack_r))
		else $error("program cycle started outside stop slot");
	AST_PROG_DEAF: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b) programming |-> o_sda_oe_b)
		else $error("data line driven while programming");
	AST_BUSY_HOLD: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_busy && (prog_cnt_r != 23'(PROG_CYCLES - 1)) |=> o_busy)
		else $error("program cycle ended early");
	AST_SEL_ACK: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b) s_good_sel |-> ##[1:8] !o_sda_oe_b)
		else $error("matching select not acknowledged");
	AST_BAD_SEL: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b) s_bad_sel |=> o_sda_oe_b [*8])
		else $error("mismatched select acknowledged");
	AST_WP_NOACK: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b) s_wp_data |=> o_sda_oe_b [*8])
		else $error("protected data byte acknowledged");
	AST_RD_NACK: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		scl_rise && in_ack && state_r == SEE_RDATA && !ack_r && sda_s |=> state_r == SEE_IDLE)
		else $error("read went on after no acknowledge");

	assign o_sda      = 1'b0;
	assign o_sda_oe_b = !drive_r;
	assign o_busy     = busy_r;
endmodule : see_slave
`default_nettype wire

// ===== logic/see_pkg.sv
// constants shared by the serial memory slave
package see_pkg;
	localparam logic [3:0]  SEE_TYPE_CODE   = 4'h5;   // arbitrary type code, not a real maker value
	localparam logic [2:0]  SEE_FIXED_BITS  = 3'h0;
	localparam int          SEE_ADDR_W      = 15;
	localparam int          SEE_ROW_BITS    = 6;
	localparam logic [7:0]  SEE_ERASED      = 8'hFF;
	localparam int          SEE_CLK_HZ      = 10000000;
	localparam int          SEE_PROG_TIME_US = 10000;
	localparam int          SEE_PROG_CYC    = (SEE_PROG_TIME_US / 1000) * (SEE_CLK_HZ / 1000);
	localparam logic [3:0]  SEE_ACK_SLOT    = 4'h8;
	localparam logic [3:0]  SEE_LAST_BIT    = 4'h7;
	typedef enum logic [2:0] {
		SEE_IDLE,
		SEE_SELECT,
		SEE_ADDR_HI,
		SEE_ADDR_LO,
		SEE_WDATA,
		SEE_RDATA,
		SEE_PROG
	} see_state_type;
endpackage : see_pkg

// ===== logic/see_sync.sv
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module see_sync (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_b,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_r;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			meta_r <= 1'b1;
			o_sync <= 1'b1;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule : see_sync
`default_nettype wire

// ===== dv/see_mst.sv
// two-wire bus master model: clock and data, open-drain style
`timescale 1ns/1ps
`default_nettype none
module see_mst (
	input  wire logic i_sys_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic q();
		repeat (2) @(posedge i_sys_clk);
	endtask : q
	// data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		o_sda <= b;
		q();
		o_scl <= 1'b1;
		q();
		r = i_sda;
		q();
		o_scl <= 1'b0;
		q();
	endtask : bit_io
	task automatic start();
		o_sda <= 1'b1;
		q();
		o_scl <= 1'b1;
		q();
		o_sda <= 1'b0;
		q();
		o_scl <= 1'b0;
		q();
	endtask : start
	task automatic stop();
		o_sda <= 1'b0;
		q();
		o_scl <= 1'b1;
		q();
		o_sda <= 1'b1;
		q();
		q();
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : wbyte
	// a high ninth bit ends the read
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(~mack, r);
	endtask : rbyte
endmodule : see_mst
`default_nettype wire

// ===== dv/see_slave_tb.sv
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module see_slave_tb;
	import see_pkg::*;
	logic      i_sys_clk;
	logic      i_rst_b;
	logic      wp;
	logic      scl;
	logic      msda;
	logic      o_sda;
	logic      o_sda_oe_b;
	logic      o_busy;
	int        error_cnt;
	int        checked;
	wire logic sda = msda & (o_sda_oe_b | o_sda);
	see_slave #(.PROG_CYCLES(200)) DUT (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_scl(scl),
		.i_sda(sda),
		.i_write_protect_input(wp),
		.o_sda(o_sda),
		.o_sda_oe_b(o_sda_oe_b),
		.o_busy(o_busy)
	);
	see_mst M (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda(msda));
	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic [7:0] d, input logic ea);
		logic a;
		M.wbyte(d, a);
		chk({7'h0, a}, {7'h0, ea});
	endtask : wb
	task automatic sa(input logic [15:0] a);
		M.start();
		wb({SEE_TYPE_CODE, SEE_FIXED_BITS, 1'b0}, 1'b1);
		wb(a[15:8], 1'b1);
		wb(a[7:0], 1'b1);
	endtask : sa
	task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
		logic [7:0] d;
		sa(a);
		M.start();
		wb({SEE_TYPE_CODE, SEE_FIXED_BITS, 1'b1}, 1'b1);
		M.rbyte(1'b1, d);
		chk(d, e0);
		M.rbyte(1'b0, d);
		chk(d, e1);
		M.stop();
		M.start();
		wb({SEE_TYPE_CODE, SEE_FIXED_BITS, 1'b1}, 1'b1);
		M.rbyte(1'b0, d);
		chk(d, SEE_ERASED);
		M.stop();
	endtask : rd2
	// polls once while programming, then waits past the shortened cycle
	task automatic pw();
		chk({7'h0, o_busy}, 8'h01);
		M.start();
		wb({SEE_TYPE_CODE, SEE_FIXED_BITS, 1'b0}, 1'b0);
		M.stop();
		repeat (400) @(posedge i_sys_clk);
		chk({7'h0, o_busy}, 8'h00);
	endtask : pw
	task automatic t_bad();
		M.start();
		wb({SEE_TYPE_CODE ^ 4'h1, SEE_FIXED_BITS, 1'b0}, 1'b0);
		M.stop();
	endtask : t_bad
	// protect raised only for the start, select and address bytes still blocks the write
	task automatic t_prot();
		wp <= 1'b1;
		sa(16'h0100);
		wp <= 1'b0;
		wb(8'h55, 1'b0);
		M.stop();
		chk({7'h0, o_busy}, 8'h00);
		rd2(16'h0100, SEE_ERASED, SEE_ERASED);
	endtask : t_prot
	task automatic t_page();
		sa(16'h003F);
		wb(8'hA1, 1'b1);
		wb(8'h5E, 1'b1);
		M.stop();
		pw();
		rd2(16'h003F, 8'hA1, SEE_ERASED);
		rd2(16'h7FFF, SEE_ERASED, 8'h5E);
	endtask : t_page
	task automatic t_byte();
		sa(16'h1234);
		wb(8'hC3, 1'b1);
		M.stop();
		pw();
		rd2(16'h1233, SEE_ERASED, 8'hC3);
	endtask : t_byte
	initial begin
		error_cnt = 0;
		checked = 0;
		i_rst_b = 1'b0;
		wp = 1'b0;
		repeat (3) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		t_bad();
		t_prot();
		t_page();
		t_byte();
		test_done();
	end
	initial begin
		repeat (30000) @(posedge i_sys_clk);
		error_cnt++;
		test_done();
	end
endmodule : see_slave_tb
`default_nettype wire
